// ---- src/mpvc_pkg.sv ----
// package: constants, types and register map of the motion profile block
// Notes on behaviour
// - bit 9 clear: finish move, then next
// - bit 9 set: hold profile speed through target
// - actual position sampled once per cycle
// - nonzero end speed: sample becomes relative base
// - ramp type 0 free jerk, 3 four jerk limits
// - ramp type resets to 0
// - profile moves never exceed max acceleration or max braking, except quick stop
// - quick stop brakes with quick-stop deceleration
// - profile speed is top, end speed at target
// - positions wrap inside the modulo range
// - home offset shifts internal zero to machine
// - velocity mode uses only unjerked ramps
// - halt stops; edges brake or restart ramp
// - bit 11 set while target outside limits
// - ramp tracks target; bit 11 while limited
// - scale 1/1 means rpm, else rps fraction
// - revolution type 0 electrical, 1 mechanical
// - ramp rate is speed change over seconds
// - target below minimum clamps to minimum
// - target above maximum clamps to maximum
// - ramps and positioning processed once per 1 ms cycle, bus every clock
package mpvc_pkg;
  // clock and application cycle
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLE_MS = 1;
  localparam int TICKS_PER_S = 1000 / CYCLE_MS;
  localparam int TICK_CYC = CLK_HZ / TICKS_PER_S;
  localparam int TCNT_W = 16;
  // motor pole pairs for electrical to mechanical speed
  localparam int POLE_PAIRS = 4;
  // register map, word index; byte address is four times it
  localparam int NREG = 34;
  localparam int REG_AW = 6;
  localparam logic [5:0] R_CTRL = 6'h00, R_MODE = 6'h01, R_STAT = 6'h02;
  localparam logic [5:0] R_TVEL = 6'h03, R_VMIN = 6'h04, R_VMAX = 6'h05;
  localparam logic [5:0] R_ADV = 6'h06, R_ADT = 6'h07, R_DDV = 6'h08;
  localparam logic [5:0] R_DDT = 6'h09, R_QDV = 6'h0A, R_QDT = 6'h0B;
  localparam logic [5:0] R_ROUT = 6'h0C, R_AVEL = 6'h0D, R_SNUM = 6'h0E;
  localparam logic [5:0] R_SDEN = 6'h0F, R_REVT = 6'h10, R_RTYP = 6'h11;
  localparam logic [5:0] R_TPOS = 6'h12, R_PVEL = 6'h13, R_EVEL = 6'h14;
  localparam logic [5:0] R_PACC = 6'h15, R_PDEC = 6'h16, R_MACC = 6'h17;
  localparam logic [5:0] R_MDEC = 6'h18, R_PQS = 6'h19, R_RLO = 6'h1A;
  localparam logic [5:0] R_RHI = 6'h1B, R_HOME = 6'h1C, R_JRK1 = 6'h1D;
  localparam logic [5:0] R_JRK2 = 6'h1E, R_JRK3 = 6'h1F, R_JRK4 = 6'h20;
  localparam logic [5:0] R_PDEM = 6'h21;
  // control word and status word bits
  localparam int CW_NEWSP = 4, CW_REL = 6, CW_HALT = 8, CW_CONT = 9;
  localparam int SW_REACH = 10, SW_LIMIT = 11, SW_BUSY = 12;
  // settings and reset values
  localparam logic [31:0] RAMP_TRAP = 32'h0, RAMP_JERK = 32'h3;
  localparam logic [31:0] REV_ELEC = 32'h0, REV_MECH = 32'h1;
  localparam logic [31:0] RST_ONE = 32'h1, RST_VMAX = 32'h7FFF_FFFF;
  localparam logic [31:0] SPD_RPM_S = 32'h3C;
  // operation modes
  typedef enum logic [7:0] {
    MPVC_MODE_POS = 8'h01,
    MPVC_MODE_VEL = 8'h02
  } mpvc_mode_t;
  // positioning sequencer
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_MOVE = 2'b01,
    PS_STOP = 2'b10
  } mpvc_pstate_t;
  // whole state of the block
  typedef struct packed {
    logic [NREG-1:0][31:0] regs;
    logic wr_pend;
    logic [REG_AW-1:0] wr_idx;
    logic [31:0] rdata;
    logic [TCNT_W-1:0] tcnt;
    logic tick;
    logic sp_q;
    logic signed [31:0] vr;
    logic signed [31:0] pv;
    logic signed [31:0] pa;
    logic signed [31:0] pos;
    logic signed [31:0] tgt;
    logic signed [31:0] base;
    logic signed [31:0] pend_tgt;
    logic signed [31:0] pos_smp;
    logic signed [31:0] act_v;
    logic signed [31:0] spd;
    logic signed [31:0] pcmd;
    logic pend_v;
    logic reached;
    logic limit;
    mpvc_pstate_t ps;
  } mpvc_state_t;
endpackage

// ---- src/mpvc_top.sv ----
// motion profile and velocity ramp logic behind an AHB-Lite register slave
module mpvc_top
  import mpvc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic signed [31:0] act_pos,
  input wire logic signed [31:0] act_vel,
  input wire logic quick_stop_active,
  output logic signed [31:0] speed_cmd_rpm,
  output logic signed [31:0] pos_cmd,
  output logic app_tick
);

  mpvc_state_t s, n; // registered state and its next value

  // magnitude of a signed word
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // step a value toward a goal by at most step
  function automatic logic signed [31:0] toward(
    input logic signed [31:0] cur,
    input logic signed [31:0] goal,
    input logic [31:0] step);
    logic signed [32:0] d;
    logic signed [32:0] dm;
    d = 33'(goal) - 33'(cur);
    dm = d[32] ? -d : d;
    if (dm <= $signed({1'b0, step})) begin
      toward = goal;
    end else if (d[32]) begin
      toward = cur - $signed(step);
    end else begin
      toward = cur + $signed(step);
    end
  endfunction

  // speed change per cycle from a change over whole seconds
  function automatic logic [31:0] ramp_step(
    input logic [31:0] dv,
    input logic [31:0] dt);
    logic [63:0] den;
    den = 64'(dt) * 64'(TICKS_PER_S);
    if (dt == 32'h0) begin
      ramp_step = dv;
    end else begin
      ramp_step = 32'(64'(dv) / den);
    end
  endfunction

  // fold a position into the modulo window when one is set
  function automatic logic signed [31:0] wrapp(
    input logic signed [31:0] p,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi);
    wrapp = p;
    if (hi > lo) begin
      if (p > hi) begin
        wrapp = p - (hi - lo);
      end else if (p < lo) begin
        wrapp = p + (hi - lo);
      end
    end
  endfunction

  // user speed to mechanical rpm for the speed loop
  function automatic logic signed [31:0] to_rpm(
    input logic signed [31:0] u,
    input logic [31:0] num,
    input logic [31:0] den,
    input logic [31:0] rev);
    logic signed [63:0] w;
    w = 64'(u);
    if (num == RST_ONE && den == RST_ONE) begin
      w = 64'(u);
    end else if (num == 32'h0) begin
      w = '0;
    end else begin
      w = (w * $signed({32'h0, den}) * $signed({32'h0, SPD_RPM_S}))
          / $signed({32'h0, num});
    end
    if (rev == REV_ELEC) begin
      w = w / 64'(POLE_PAIRS);
    end
    to_rpm = 32'(w);
  endfunction

  // registers that software may not write
  function automatic logic is_ro(input logic [REG_AW-1:0] i);
    is_ro = (i == R_STAT) || (i == R_ROUT) || (i == R_AVEL) ||
            (i == R_PDEM) || (i >= REG_AW'(NREG));
  endfunction

  logic aph; // address phase accepted
  logic [REG_AW-1:0] aidx; // word index of the address phase
  logic amap; // address falls inside the register file
  logic [31:0] cw; // control word seen by the logic
  logic [31:0] rv; // read value of the addressed register
  logic vel_md, pos_md, qs, jerk_on, sp_rise, hit, lim_rng;
  logic [31:0] tm, vmn, vmx, stp, amax, dmax, ve, vm, vmn2, remm, jst;
  logic [63:0] db;
  logic signed [31:0] tc, rem, want, an, vfl, span, nt;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign speed_cmd_rpm = s.spd;
  assign pos_cmd = s.pcmd;
  assign app_tick = s.tick;
  assign aph = hsel && hready && htrans[1];
  assign aidx = haddr[REG_AW+1:2];
  assign amap = (haddr[31:REG_AW+2] == '0) && (aidx < REG_AW'(NREG));

  // next state: bus slave, cycle divider, velocity ramp, positioning
  always_comb begin
    n = s;
    // bus write lands in its data phase
    n.wr_pend = aph && hwrite && amap;
    n.wr_idx = aidx;
    if (s.wr_pend && !is_ro(s.wr_idx)) begin
      n.regs[s.wr_idx] = hwdata;
    end
    cw = n.regs[R_CTRL];
    // read value, live status for read-only words
    case (aidx)
      R_STAT: rv = {19'h0, s.pend_v, s.limit, s.reached, 10'h0};
      R_ROUT: rv = s.vr;
      R_AVEL: rv = s.act_v;
      R_PDEM: rv = s.pos;
      default: rv = amap ? s.regs[aidx] : 32'h0;
    endcase
    if (s.wr_pend && s.wr_idx == aidx && !is_ro(aidx)) begin
      rv = hwdata;
    end
    if (aph && !hwrite) begin
      n.rdata = rv;
    end
    // application cycle divider
    n.tick = (s.tcnt == TCNT_W'(TICK_CYCLES - 1));
    n.tcnt = n.tick ? '0 : s.tcnt + 1'b1;
    vel_md = s.regs[R_MODE][7:0] == MPVC_MODE_VEL;
    pos_md = s.regs[R_MODE][7:0] == MPVC_MODE_POS;
    qs = quick_stop_active;
    // velocity mode target clamp
    tm = abs32($signed(s.regs[R_TVEL]));
    vmn = s.regs[R_VMIN];
    vmx = s.regs[R_VMAX];
    lim_rng = (tm < vmn) || (tm > vmx);
    if (tm > vmx) begin
      tm = vmx;
    end else if (tm < vmn) begin
      tm = vmn;
    end
    tc = s.regs[R_TVEL][31] ? -$signed(tm) : $signed(tm);
    if (cw[CW_HALT] || qs) begin
      tc = '0;
    end
    // unjerked ramp rate: accelerate, decelerate or quick stop
    if (qs) begin
      stp = ramp_step(s.regs[R_QDV], s.regs[R_QDT]);
    end else if ((tc[31] == s.vr[31] || s.vr == '0) &&
                 abs32(tc) > abs32(s.vr)) begin
      stp = ramp_step(s.regs[R_ADV], s.regs[R_ADT]);
    end else begin
      stp = ramp_step(s.regs[R_DDV], s.regs[R_DDT]);
    end
    // positioning limits and end speed
    amax = (s.regs[R_PACC] < s.regs[R_MACC]) ? s.regs[R_PACC]
         : s.regs[R_MACC];
    dmax = (s.regs[R_PDEC] < s.regs[R_MDEC]) ? s.regs[R_PDEC]
         : s.regs[R_MDEC];
    if (qs) begin
      dmax = s.regs[R_PQS];
    end
    ve = (cw[CW_CONT] && s.pend_v) ? s.regs[R_PVEL]
       : s.regs[R_EVEL];
    span = $signed(s.regs[R_RHI]) - $signed(s.regs[R_RLO]);
    rem = s.tgt - s.pos;
    if (span > 0) begin
      if (rem > (span >>> 1)) begin
        rem = rem - span;
      end else if (rem < -(span >>> 1)) begin
        rem = rem + span;
      end
    end
    remm = abs32(rem);
    vm = abs32(s.pv);
    db = '0;
    if (vm > ve && dmax != '0) begin
      db = (64'(vm) * 64'(vm) - 64'(ve) * 64'(ve)) / (64'(dmax) << 1);
    end
    // wanted acceleration along the direction of travel
    vfl = $signed(s.regs[R_PVEL]);
    if (qs) begin
      want = -$signed(dmax);
      vfl = '0;
    end else if (64'(remm) <= db + 64'(vm) && vm > ve) begin
      want = -$signed(dmax);
      vfl = $signed(ve);
    end else if (vm < s.regs[R_PVEL]) begin
      want = $signed(amax);
    end else if (vm > s.regs[R_PVEL]) begin
      want = -$signed(dmax);
    end else begin
      want = '0;
    end
    // jerk limit on the acceleration in ramp type three
    jerk_on = s.regs[R_RTYP] == RAMP_JERK;
    if (want > s.pa) begin
      jst = (s.pa >= 0) ? s.regs[R_JRK1] : s.regs[R_JRK4];
    end else begin
      jst = (s.pa > 0) ? s.regs[R_JRK2] : s.regs[R_JRK3];
    end
    an = jerk_on ? toward(s.pa, want, jst) : want;
    if (an > 0) begin
      vmn2 = 32'(toward($signed(vm), vfl, 32'(an)));
    end else if (an < 0) begin
      vmn2 = 32'(toward($signed(vm), vfl, 32'(-an)));
    end else begin
      vmn2 = vm;
    end
    hit = !qs && (vmn2 >= remm);
    sp_rise = cw[CW_NEWSP] && !s.sp_q;
    nt = wrapp(cw[CW_REL] ? s.base + $signed(s.regs[R_TPOS])
                          : $signed(s.regs[R_TPOS]),
               $signed(s.regs[R_RLO]), $signed(s.regs[R_RHI]));
    // work once per application cycle
    if (s.tick) begin
      n.sp_q = cw[CW_NEWSP];
      n.pos_smp = act_pos;
      n.act_v = act_vel;
      // velocity ramp generator
      if (vel_md) begin
        n.vr = toward(s.vr, tc, stp);
        n.limit = lim_rng || (n.vr != tc);
        n.reached = n.vr == tc;
      end else begin
        n.vr = '0;
        n.limit = 1'b0;
      end
      n.spd = to_rpm(n.vr, s.regs[R_SNUM], s.regs[R_SDEN],
                     s.regs[R_REVT]);
      // positioning sequencer
      case (s.ps)
        PS_IDLE: begin
          n.pv = '0;
          n.pa = '0;
          n.pend_v = 1'b0;
          if (pos_md && sp_rise && !qs) begin
            n.tgt = nt;
            n.ps = PS_MOVE;
            n.reached = 1'b0;
          end
        end
        PS_MOVE: begin
          n.pa = an;
          if (pos_md && sp_rise && !s.pend_v) begin
            n.pend_v = 1'b1;
            n.pend_tgt = $signed(s.regs[R_TPOS]);
          end
          if (!pos_md) begin
            n.ps = PS_IDLE;
          end else if (hit) begin
            // reached: settle or carry speed into the next move
            n.base = (s.regs[R_EVEL] != '0) ? act_pos : s.tgt;
            n.pos = (ve == '0) ? s.tgt
                  : wrapp(s.pos + (rem[31] ? -$signed(vmn2)
                                           : $signed(vmn2)),
                          $signed(s.regs[R_RLO]),
                          $signed(s.regs[R_RHI]));
            if (s.pend_v) begin
              n.tgt = wrapp(cw[CW_REL] ? n.base + s.pend_tgt : s.pend_tgt,
                            $signed(s.regs[R_RLO]),
                            $signed(s.regs[R_RHI]));
              n.pend_v = 1'b0;
              n.pv = rem[31] ? -$signed(ve) : $signed(ve);
            end else begin
              n.ps = PS_IDLE;
              n.reached = 1'b1;
            end
          end else begin
            n.pv = rem[31] ? -$signed(vmn2) : $signed(vmn2);
            n.pos = wrapp(s.pos + n.pv, $signed(s.regs[R_RLO]),
                          $signed(s.regs[R_RHI]));
            if (qs && vmn2 == '0) begin
              n.ps = PS_STOP;
            end
          end
        end
        PS_STOP: begin
          // stopped by quick stop; wait for release
          n.pv = '0;
          n.pa = '0;
          n.pend_v = 1'b0;
          n.base = s.pos;
          if (!qs) begin
            n.ps = PS_IDLE;
          end
        end
        default: begin
          n.ps = PS_IDLE;
        end
      endcase
      n.pcmd = n.pos + $signed(s.regs[R_HOME]);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.regs[R_VMAX] <= RST_VMAX;
      s.regs[R_SNUM] <= RST_ONE;
      s.regs[R_SDEN] <= RST_ONE;
      s.regs[R_REVT] <= REV_MECH;
      s.regs[R_RTYP] <= RAMP_TRAP;
      s.ps <= PS_IDLE;
    end else begin
      s <= n;
    end
  end

  // checks
  logic vmode_q; // velocity mode seen by the checks
  assign vmode_q = s.regs[R_MODE][7:0] == MPVC_MODE_VEL;

  property p_tick_only;
    @(posedge hclk) disable iff (!hresetn)
      !s.tick |=> $stable(s.vr) && $stable(s.pos);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("ramp moved outside the application cycle");

  property p_tick_gap;
    @(posedge hclk) disable iff (!hresetn)
      s.tick |=> !s.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("cycle pulse longer than one clock");

  property p_limit_hi;
    @(posedge hclk) disable iff (!hresetn)
      s.tick && vmode_q && !s.regs[R_TVEL][31] && !s.wr_pend &&
      s.regs[R_TVEL] > s.regs[R_VMAX] |=> s.limit;
  endproperty
  a_limit_hi: assert property (p_limit_hi)
    else $error("limit flag missing for target above maximum");

  property p_clamp_max;
    @(posedge hclk) disable iff (!hresetn)
      s.tick && vmode_q && !cw[CW_HALT] && !quick_stop_active &&
      !s.regs[R_TVEL][31] && s.vr >= 0 |=>
      s.vr <= $signed($past(s.regs[R_VMAX]));
  endproperty
  a_clamp_max: assert property (p_clamp_max)
    else $error("ramp output above maximum speed");

  property p_halt_hold;
    @(posedge hclk) disable iff (!hresetn)
      s.tick && vmode_q && cw[CW_HALT] && s.vr == 0 |=> s.vr == 0;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("motor left standstill under halt");

  property p_accel_step;
    @(posedge hclk) disable iff (!hresetn)
      s.tick && vmode_q && !quick_stop_active && s.vr >= 0 &&
      tc > s.vr |=> s.vr - $past(s.vr) <= $signed($past(stp));
  endproperty
  a_accel_step: assert property (p_accel_step)
    else $error("ramp step larger than the acceleration rate");

  property p_qs_brake;
    @(posedge hclk) disable iff (!hresetn)
      s.tick && vmode_q && quick_stop_active && s.vr > 0 &&
      stp != 0 |=> s.vr < $past(s.vr);
  endproperty
  a_qs_brake: assert property (p_qs_brake)
    else $error("no braking under quick stop");

  property p_sample;
    @(posedge hclk) disable iff (!hresetn)
      s.tick |=> s.pos_smp == $past(act_pos) ##1 $stable(s.pos_smp);
  endproperty
  a_sample: assert property (p_sample)
    else $error("position sample not taken once per cycle");

  property p_home;
    @(posedge hclk) disable iff (!hresetn)
      s.tick ##1 1'b1 |-> s.pcmd == s.pos + $signed($past(s.regs[R_HOME]));
  endproperty
  a_home: assert property (p_home)
    else $error("position output misses the home offset");

  c_vel_limit: cover property (@(posedge hclk) s.tick && s.limit && vmode_q);
  c_pos_hit: cover property (@(posedge hclk) s.tick && s.ps == PS_MOVE && hit);
  c_qs_stop: cover property (@(posedge hclk) s.ps == PS_STOP);

endmodule

// ---- testbench/mpvc_master.sv ----
// partner model: fieldbus master issuing single AHB-Lite word transfers
module mpvc_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus starts idle, whole-word size only
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // one transfer: address phase, then data phase, each held until ready
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    // reads put a changing pattern on the unused write lanes
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    // read data taken at the edge that ends the data phase
    rd = hrdata;
  endtask
endmodule

// ---- testbench/motion_profile_velocity_control_tb.sv ----
// self-checking bench for the motion profile and velocity ramp block
module motion_profile_velocity_control_tb import mpvc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TK = 20; // short application cycle for simulation
  logic hclk, hresetn, hready, hresp, app_tick, quick_stop;
  logic hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, a, b, c;
  logic signed [31:0] act_pos, act_vel, spd, pcmd;
  int err_total, checked, cyc;

  mpvc_top #(.TICK_CYCLES(TK)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .act_pos(act_pos), .act_vel(act_vel),
    .quick_stop_active(quick_stop), .speed_cmd_rpm(spd), .pos_cmd(pcmd),
    .app_tick(app_tick));

  mpvc_master master_u (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // 100 ns clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      report_and_stop;
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    master_u.xfer(1'b1, i, d, rd);
  endtask
  task automatic rdv(input logic [5:0] i, output logic [31:0] v);
    master_u.xfer(1'b0, i, 32'h0, v);
  endtask
  task automatic rdchk(input logic [5:0] i, input logic [31:0] e);
    rdv(i, rd);
    chk(rd, e);
  endtask
  // wait for n application cycles to be processed
  task automatic ticks(input int n);
    repeat (n) @(posedge hclk iff app_tick === 1'b1);
  endtask
  // ramp output change over one application cycle
  task automatic slope(input logic [31:0] step);
    ticks(1);
    rdv(R_ROUT, a);
    ticks(1);
    rdv(R_ROUT, b);
    chk(b - a, step);
  endtask

  // reset values, unmapped and read-only places, home offset
  task automatic t_reset;
    rdchk(R_RTYP, RAMP_TRAP);
    rdchk(R_VMAX, RST_VMAX);
    rdchk(R_SNUM, RST_ONE);
    rdchk(R_SDEN, RST_ONE);
    rdchk(R_REVT, REV_MECH);
    rdchk(6'h30, 32'h0);
    chk(hresp, 32'h0);
    wr(R_ROUT, 32'h1234);
    rdchk(R_ROUT, 32'h0);
    wr(R_HOME, 32'h3E8);
    ticks(2);
    chk(pcmd, 32'h3E8);
    $display("test reset done");
  endtask

  // velocity ramp with jerk type selected, which must be ignored
  task automatic t_ramp;
    wr(R_ADV, 32'h1388);
    wr(R_ADT, 32'h1);
    wr(R_DDV, 32'h2710);
    wr(R_DDT, 32'h1);
    wr(R_QDV, 32'h61A8);
    wr(R_QDT, 32'h1);
    wr(R_RTYP, RAMP_JERK);
    wr(R_JRK1, 32'h1);
    wr(R_TVEL, 32'h28);
    wr(R_MODE, 32'h2);
    slope(32'h5);
    rdv(R_STAT, rd);
    chk(rd[SW_LIMIT], 1'b1);
    ticks(10);
    rdchk(R_ROUT, 32'h28);
    rdv(R_STAT, rd);
    chk(rd[SW_LIMIT], 1'b0);
    chk(spd, 32'h28);
    rdchk(R_AVEL, 32'h7B);
    wr(R_RTYP, RAMP_TRAP);
    $display("test ramp done");
  endtask

  // halt brakes on the deceleration ramp, release accelerates again
  task automatic t_halt;
    wr(R_CTRL, 32'h100);
    slope(32'hFFFF_FFF6);
    ticks(5);
    rdchk(R_ROUT, 32'h0);
    wr(R_CTRL, 32'h0);
    slope(32'h5);
    ticks(10);
    rdchk(R_ROUT, 32'h28);
    $display("test halt done");
  endtask

  // clamping to maximum and minimum with the limit flag
  task automatic t_clamp;
    wr(R_VMAX, 32'h1E);
    ticks(3);
    rdchk(R_ROUT, 32'h1E);
    rdv(R_STAT, rd);
    chk(rd[SW_LIMIT], 1'b1);
    wr(R_VMAX, RST_VMAX);
    wr(R_VMIN, 32'h32);
    wr(R_TVEL, 32'h3);
    ticks(10);
    rdchk(R_ROUT, 32'h32);
    rdv(R_STAT, rd);
    chk(rd[SW_LIMIT], 1'b1);
    $display("test clamp done");
  endtask

  // unit scaling and revolution basis at 50 units
  task automatic t_scale;
    wr(R_SNUM, 32'h2);
    ticks(2);
    chk(spd, 32'h5DC);
    wr(R_REVT, REV_ELEC);
    ticks(2);
    chk(spd, 32'h177);
    wr(R_SNUM, RST_ONE);
    wr(R_REVT, REV_MECH);
    $display("test scale done");
  endtask

  // quick stop brakes with its own ramp
  task automatic t_qstop;
    @(posedge hclk);
    quick_stop <= 1'b1;
    slope(32'hFFFF_FFE7);
    ticks(2);
    rdchk(R_ROUT, 32'h0);
    @(posedge hclk);
    quick_stop <= 1'b0;
    wr(R_VMIN, 32'h0);
    $display("test quick stop done");
  endtask

  // positioning start: acceleration bounded by the smaller limit
  task automatic t_pos;
    wr(R_PVEL, 32'h64);
    wr(R_PACC, 32'h2);
    wr(R_MACC, 32'h1);
    wr(R_PDEC, 32'h64);
    wr(R_MDEC, 32'h64);
    wr(R_TPOS, 32'h186A0);
    wr(R_MODE, 32'h1);
    ticks(1);
    wr(R_CTRL, 32'h10);
    ticks(3);
    rdv(R_PDEM, a);
    ticks(1);
    rdv(R_PDEM, b);
    ticks(1);
    rdv(R_PDEM, c);
    chk((c - b) - (b - a), 32'h1);
    $display("test position done");
  endtask

  // verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    quick_stop = 1'b0;
    act_pos = 32'sh0;
    act_vel = 32'sh7B;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_ramp;
    t_halt;
    t_clamp;
    t_scale;
    t_qstop;
    t_pos;
    report_and_stop;
  end
endmodule
